// ==== scfg_defs.vh ====
/*
  Constants for the sensor configuration lock word block: register
  offsets, field positions, codes and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SCFG_DEFS_VH
`define SCFG_DEFS_VH

// Word index of the configuration word, byte address is four times it
`define SCFG_CFG_IDX        6'h09
`define SCFG_ADDR_CFG       8'h24
`define SCFG_ADDR_NVM_CTL   8'h40
`define SCFG_ADDR_STATUS    8'h44
`define SCFG_ADDR_CLEAR     8'h48
`define SCFG_ADDR_ENABLE    8'h4c
`define SCFG_ADDR_MON       8'h50

`define SCFG_CFG_W          26
`define SCFG_CFG_RESET      26'h0000000
`define SCFG_CFG_WMASK      26'h3ffffff

`define SCFG_LOCK_LSB       0
`define SCFG_LOCK_MSB       2
`define SCFG_LOCK_NVM       3'h3
`define SCFG_LOCK_FULL      3'h5
`define SCFG_TRIG_LSB       10
`define SCFG_TRIG_MSB       11
`define SCFG_IMM_BIT        12
`define SCFG_COIL_LSB       13
`define SCFG_COIL_MSB       14
`define SCFG_SPARE_BIT      15
`define SCFG_COMP_DIS_BIT   16
`define SCFG_DIAG_MODE_BIT  17
`define SCFG_LST_DIS_BIT    18
`define SCFG_COIL_MON_BIT   19
`define SCFG_UV_DIS_BIT     20
`define SCFG_OV_DIS_BIT     21

`define SCFG_COIL_ON        2'h0
`define SCFG_COIL_HALF      2'h1
`define SCFG_COIL_1_256     2'h2
`define SCFG_COIL_OFF       2'h3

// Trigger ticks: code plus this base
`define SCFG_TRIG_BASE      4'h7

// Settle delay before first message, in microseconds and cycles
`define SCFG_CLK_MHZ        50
`define SCFG_SETTLE_US      1000
`define SCFG_SETTLE_CYC     (`SCFG_SETTLE_US * `SCFG_CLK_MHZ)

// Status bits
`define SCFG_ST_NVM_REJ     0
`define SCFG_ST_REG_REJ     1
`define SCFG_ST_LST_IGN     2
`define SCFG_ST_W           3

`define SCFG_RESP_OKAY      2'h0
`define SCFG_RESP_SLVERR    2'h2

`endif

// ==== scfg_coil_duty.v ====
/*
  Compensation coil duty generator: turns the two-bit duty code into
  the coil drive level with an 8-bit phase counter.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "scfg_defs.vh"

module scfg_coil_duty (
  // Clock and reset
  input  wire       clock,
  input  wire       nrst,
  // Duty code
  input  wire [1:0] duty_code,
  // Coil drive
  output reg        coil_on
);

  reg [7:0] phase_reg;

  always @(posedge clock) begin
    if (!nrst) begin
      phase_reg <= 8'h00;
      coil_on   <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 8'h01;
      case (duty_code)
        `SCFG_COIL_ON:    coil_on <= 1'b1;
        `SCFG_COIL_HALF:  coil_on <= phase_reg[0];
        `SCFG_COIL_1_256: coil_on <= (phase_reg == 8'hff);
        `SCFG_COIL_OFF:   coil_on <= 1'b0;
        default:          coil_on <= 1'b0;
      endcase
    end
  end

endmodule

// ==== scfg_top.v ====
/*
  Configuration lock word with AXI4-Lite register access, lock gating of
  register and non-volatile writes, and decode of the option fields.
  Assumes an AXI4-Lite master that keeps one write and one read open.
*/
// How it works
// - Lock level 3 refuses non-volatile writes but keeps register writes and all reads.
// - Lock level 5 refuses non-volatile writes and configuration and enable register writes but answers all reads.
// - Lock levels 0, 1, 2, 4, 6 and 7 in bits 2..0 permit all reads and writes.
// - The trigger low-time select picks 7, 8, 9 or 10 ticks for codes 0 to 3.
// - First-message option 0 waits for the signal path to settle, 1 sends at once.
// - Coil duty code 0 always on, 1 half, 2 one in 256, 3 always off.
// - A triggered coil self-test is allowed only while the coil is off.
// - Bit 16 set disables coil drift compensation.
// - Bit 17 clear reports a diagnostic as a diag message in PWM or SENT.
// - Bit 17 set floats the output on diagnostic error, only in PWM format 0.
// - Bit 18 set ignores a logic self-test request, clear runs it.
// - Bit 19 set mutes coil monitor errors at the output.
// - Bit 20 set mutes undervoltage errors at the output.
// - Bit 21 set mutes overvoltage errors at the output.
`timescale 1ns/1ps
`include "scfg_defs.vh"

module scfg_top #(
  parameter SETTLE_CYCLES = `SCFG_SETTLE_CYC
) (
  // Clock and reset
  input  wire        clock,
  input  wire        nrst,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Non-volatile memory write port
  output reg         nvm_wr,
  output reg  [31:0] nvm_wdata,
  // Device events
  input  wire        lst_req,
  input  wire        coil_test_req,
  input  wire        diag_err,
  input  wire        coil_mon_err,
  input  wire        uv_err,
  input  wire        ov_err,
  input  wire        out_fmt_pwm,
  // Decoded controls
  output reg  [3:0]  trig_min_ticks,
  output reg         first_msg_ok,
  output reg         coil_drive,
  output reg         coil_test_go,
  output reg         comp_en,
  output reg         send_diag_msg,
  output reg         out_hiz,
  output reg         lst_run,
  output reg         coil_err_out,
  output reg         uv_err_out,
  output reg         ov_err_out,
  // Interrupt
  output reg         irq
);

  reg [`SCFG_CFG_W-1:0] cfg_reg;
  reg [`SCFG_ST_W-1:0]  status_reg;
  reg [`SCFG_ST_W-1:0]  enable_reg;
  reg [7:0]             awaddr_reg;
  reg [31:0]            wdata_reg;
  reg [3:0]             wstrb_reg;
  reg                   aw_held_reg;
  reg                   w_held_reg;
  reg [31:0]            settle_reg;
  reg                   settled_reg;

  wire [2:0] lock_lvl  = cfg_reg[`SCFG_LOCK_MSB:`SCFG_LOCK_LSB];
  wire [1:0] coil_code = cfg_reg[`SCFG_COIL_MSB:`SCFG_COIL_LSB];
  wire       coil_now;

  // Level 3 blocks only the memory
  wire nvm_lock = (lock_lvl == `SCFG_LOCK_NVM) || (lock_lvl == `SCFG_LOCK_FULL);
  wire reg_lock = (lock_lvl == `SCFG_LOCK_FULL);

  // Act only once both halves are held, so each write touches status once
  wire [7:0]  wa      = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd      = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]  ws      = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire        do_wr   = aw_held_reg && w_held_reg && !s_axi_bvalid;

  wire [31:0] bmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire [31:0] cfg_merge = ({6'h00, cfg_reg} & ~bmask) | (wd & bmask);

  wire hit_cfg = (wa == `SCFG_ADDR_CFG);
  wire hit_nvm = (wa == `SCFG_ADDR_NVM_CTL);
  wire hit_clr = (wa == `SCFG_ADDR_CLEAR);
  wire hit_en  = (wa == `SCFG_ADDR_ENABLE);
  wire hit_ro  = (wa == `SCFG_ADDR_STATUS) || (wa == `SCFG_ADDR_MON);
  wire wr_ok   = hit_cfg || hit_nvm || hit_clr || hit_en || hit_ro;

  wire rej_reg = do_wr && (hit_cfg || hit_en) && reg_lock;
  wire rej_nvm = do_wr && hit_nvm && nvm_lock;

  wire lst_ign = lst_req && cfg_reg[`SCFG_LST_DIS_BIT];

  wire [`SCFG_ST_W-1:0] st_set = {lst_ign, rej_reg, rej_nvm};
  wire [`SCFG_ST_W-1:0] st_clr = (do_wr && hit_clr) ? wd[`SCFG_ST_W-1:0] : {`SCFG_ST_W{1'b0}};

  // Write channel
  always @(posedge clock) begin
    if (!nrst) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SCFG_RESP_OKAY;
      cfg_reg       <= `SCFG_CFG_RESET;
      enable_reg    <= {`SCFG_ST_W{1'b0}};
      nvm_wr        <= 1'b0;
      nvm_wdata     <= 32'h00000000;
    end else begin
      nvm_wr <= 1'b0;
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Refused writes answer SLVERR so software sees the lock
        s_axi_bresp  <= (!wr_ok || rej_reg || rej_nvm || hit_ro) ?
                        `SCFG_RESP_SLVERR : `SCFG_RESP_OKAY;
        if (hit_cfg && !reg_lock) begin
          cfg_reg <= cfg_merge[`SCFG_CFG_W-1:0] & `SCFG_CFG_WMASK;
        end
        if (hit_en && !reg_lock) begin
          enable_reg <= wd[`SCFG_ST_W-1:0];
        end
        if (hit_nvm && !nvm_lock) begin
          nvm_wr    <= 1'b1;
          nvm_wdata <= wd;
        end
      end
    end
  end

  // Status, set wins over clear
  always @(posedge clock) begin
    if (!nrst) begin
      status_reg <= {`SCFG_ST_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~st_clr) | st_set;
      irq        <= |(((status_reg & ~st_clr) | st_set) & enable_reg);
    end
  end

  // Read channel, one cycle answer
  always @(posedge clock) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SCFG_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SCFG_RESP_OKAY;
        case (s_axi_araddr)
          `SCFG_ADDR_CFG:     s_axi_rdata <= {6'h00, cfg_reg};
          `SCFG_ADDR_STATUS:  s_axi_rdata <= {29'h0, status_reg};
          `SCFG_ADDR_ENABLE:  s_axi_rdata <= {29'h0, enable_reg};
          `SCFG_ADDR_MON:     s_axi_rdata <= {28'h0, settled_reg, coil_now, nvm_lock, reg_lock};
          `SCFG_ADDR_NVM_CTL: s_axi_rdata <= nvm_wdata;
          `SCFG_ADDR_CLEAR:   s_axi_rdata <= 32'h00000000;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SCFG_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  scfg_coil_duty u_coil (
    .clock     (clock),
    .nrst      (nrst),
    .duty_code (coil_code),
    .coil_on   (coil_now)
  );

  // Settle timer restarts only at reset
  always @(posedge clock) begin
    if (!nrst) begin
      settle_reg  <= 32'h00000000;
      settled_reg <= 1'b0;
    end else if (!settled_reg) begin
      settle_reg  <= settle_reg + 32'h00000001;
      settled_reg <= (settle_reg >= SETTLE_CYCLES - 1);
    end
  end

  // Decoded controls, all registered
  always @(posedge clock) begin
    if (!nrst) begin
      trig_min_ticks <= `SCFG_TRIG_BASE;
      first_msg_ok   <= 1'b0;
      coil_drive     <= 1'b0;
      coil_test_go   <= 1'b0;
      comp_en        <= 1'b0;
      send_diag_msg  <= 1'b0;
      out_hiz        <= 1'b0;
      lst_run        <= 1'b0;
      coil_err_out   <= 1'b0;
      uv_err_out     <= 1'b0;
      ov_err_out     <= 1'b0;
    end else begin
      trig_min_ticks <= `SCFG_TRIG_BASE + {2'b00, cfg_reg[`SCFG_TRIG_MSB:`SCFG_TRIG_LSB]};
      first_msg_ok   <= cfg_reg[`SCFG_IMM_BIT] || settled_reg;
      coil_drive     <= coil_now;
      coil_test_go   <= coil_test_req && !coil_now && (coil_code == `SCFG_COIL_OFF);
      comp_en        <= !cfg_reg[`SCFG_COMP_DIS_BIT];
      // Float only in PWM; other formats fall back to a message
      out_hiz        <= diag_err && cfg_reg[`SCFG_DIAG_MODE_BIT] && out_fmt_pwm;
      send_diag_msg  <= diag_err && !(cfg_reg[`SCFG_DIAG_MODE_BIT] && out_fmt_pwm);
      lst_run        <= lst_req && !cfg_reg[`SCFG_LST_DIS_BIT];
      coil_err_out   <= coil_mon_err && !cfg_reg[`SCFG_COIL_MON_BIT];
      uv_err_out     <= uv_err && !cfg_reg[`SCFG_UV_DIS_BIT];
      ov_err_out     <= ov_err && !cfg_reg[`SCFG_OV_DIS_BIT];
    end
  end

endmodule

// ==== scfg_props.sv ====
/* Port checker for the configuration lock word block.
   Assumes a bind onto scfg_top, one clock, sync active-low reset. */
`timescale 1ns/1ps
module scfg_props (
  // Clock and reset
  input logic       clock,
  input logic       nrst,
  // Bus and memory strobes
  input logic       s_axi_awvalid,
  input logic       s_axi_awready,
  input logic       s_axi_bvalid,
  input logic       s_axi_bready,
  input logic       nvm_wr,
  // Events and decoded controls
  input logic       lst_req,
  input logic       coil_test_req,
  input logic       diag_err,
  input logic       out_fmt_pwm,
  input logic [3:0] trig_min_ticks,
  input logic       coil_test_go,
  input logic       send_diag_msg,
  input logic       out_hiz,
  input logic       lst_run
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence s_aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_resp_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_write_answer: assert property (s_aw_taken |-> ##[1:8] s_axi_bvalid)
    else $error("write answer late");
  a_resp_hold: assert property (s_resp_wait |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_nvm_pulse: assert property (nvm_wr |=> !nvm_wr)
    else $error("nvm strobe too long");
  a_trig_ticks: assert property (trig_min_ticks inside {[4'h7:4'ha]})
    else $error("trigger ticks out of range");
  a_hiz_pwm_only: assert property (out_hiz |-> $past(diag_err) && $past(out_fmt_pwm))
    else $error("float without cause");
  a_diag_msg_cause: assert property (send_diag_msg |-> $past(diag_err) && !out_hiz)
    else $error("diag message without cause");
  a_lst_cause: assert property (lst_run |-> $past(lst_req))
    else $error("self-test without request");
  a_coil_test_req: assert property (coil_test_go |-> $past(coil_test_req))
    else $error("coil test without request");
endmodule

// ==== scfg_nvm_model.sv ====
/* Non-volatile memory sink: counts write strobes, keeps the last word.
   Assumes the block's clock and one-cycle write strobe. */
`timescale 1ns/1ps
module scfg_nvm_model (
  // Clock and reset
  input  wire        clock,
  input  wire        nrst,
  // Write port
  input  wire        nvm_wr,
  input  wire [31:0] nvm_wdata,
  // Observed state
  output reg  [7:0]  wr_cnt,
  output reg  [31:0] mem_word
);
  // Word left unreset: reading it before a write shows unknown
  always @(posedge clock) begin
    if (!nrst) begin
      wr_cnt <= 8'h00;
    end else if (nvm_wr) begin
      wr_cnt   <= wr_cnt + 8'h01;
      mem_word <= nvm_wdata;
    end
  end
endmodule

// ==== tb_top.sv ====
/* Bench for the configuration lock word block with AXI4-Lite tasks.
   Assumes the design, scfg_defs.vh and the memory sink model. */
`timescale 1ns/1ps
`include "scfg_defs.vh"
module tb_top;
  localparam OK = `SCFG_RESP_OKAY;
  localparam ER = `SCFG_RESP_SLVERR;
  localparam CF = `SCFG_ADDR_CFG;
  localparam NV = `SCFG_ADDR_NVM_CTL;
  reg         clock, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  reg         s_axi_rready, lst_req, coil_test_req, diag_err, coil_mon_err, uv_err, ov_err;
  reg         out_fmt_pwm;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nvm_wr;
  wire        first_msg_ok, coil_drive, coil_test_go, comp_en, send_diag_msg, out_hiz, irq;
  wire        lst_run, coil_err_out, uv_err_out, ov_err_out;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, nvm_wdata, mem_word;
  wire [3:0]  trig_min_ticks;
  wire [7:0]  wr_cnt;
  integer     n_mismatch, cmp_count, i, k;

  // Short settle count keeps the delayed first message inside the run
  scfg_top #(.SETTLE_CYCLES(40)) scfg_top_i (.*);
  scfg_nvm_model scfg_nvm_model_i (.*);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("%0d compares, %0d mismatches", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task tmo;
    begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  endtask

  task do_reset;
    begin
      nrst <= 1'b0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
    end
  endtask

  task axi_wr(input [7:0] a, input [31:0] d, input [1:0] e);
    begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      k = 0;
      do begin
        @(posedge clock);
        k = k + 1;
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && k < 50);
      if (!s_axi_bvalid)
        tmo;
      check(s_axi_bresp, e);
    end
  endtask

  task axi_rd(input [7:0] a, input [31:0] d, input [1:0] e);
    begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      k = 0;
      do begin
        @(posedge clock);
        k = k + 1;
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && k < 50);
      if (!s_axi_rvalid)
        tmo;
      check(s_axi_rresp, e);
      check(s_axi_rdata, d);
    end
  endtask

  task t_reset;
    begin
      do_reset;
      axi_rd(CF, 32'h0, OK);
      check(trig_min_ticks, 4'h7);
      check(comp_en, 1'b1);
      check(first_msg_ok, 1'b0);
      repeat (40) @(posedge clock);
      check(first_msg_ok, 1'b1);
      do_reset;
      axi_wr(CF, 32'h1000, OK);
      repeat (2) @(posedge clock);
      check(first_msg_ok, 1'b1);
      $display("reset test done");
    end
  endtask

  task t_fields;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        axi_wr(CF, (i << 10) | (i[0] << 16) | 32'h8000, OK);
        repeat (2) @(posedge clock);
        check(trig_min_ticks, 4'h7 + i);
        check(comp_en, !i[0]);
        axi_rd(CF, (i << 10) | (i[0] << 16) | 32'h8000, OK);
      end
      axi_wr(CF, 32'hffffffff, OK);
      axi_rd(CF, 32'h03ffffff, OK);
      s_axi_wstrb <= 4'h1;
      axi_wr(CF, 32'h0, OK);
      s_axi_wstrb <= 4'hf;
      axi_rd(CF, 32'h03ffff00, OK);
      $display("field test done");
    end
  endtask

  task t_coil;
    begin
      coil_test_req <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        axi_wr(CF, i << 13, OK);
        repeat (4) @(posedge clock);
        k = 0;
        repeat (512) begin
          @(posedge clock);
          k = k + coil_drive;
        end
        check(k, i == 0 ? 32'h200 : i == 1 ? 32'h100 : i == 2 ? 32'h2 : 32'h0);
        check(coil_test_go, i == 3);
      end
      coil_test_req <= 1'b0;
      $display("coil test done");
    end
  endtask

  task t_mute;
    begin
      {lst_req, coil_mon_err, uv_err, ov_err, diag_err, out_fmt_pwm} <= 6'h3f;
      for (i = 0; i < 2; i = i + 1) begin
        axi_wr(CF, i ? 32'h003e0000 : 32'h0, OK);
        repeat (3) @(posedge clock);
        check(lst_run, !i[0]);
        check(coil_err_out, !i[0]);
        check(uv_err_out, !i[0]);
        check(ov_err_out, !i[0]);
        check(send_diag_msg, !i[0]);
        check(out_hiz, i[0]);
      end
      axi_rd(`SCFG_ADDR_STATUS, 32'h4, OK);
      out_fmt_pwm <= 1'b0;
      repeat (3) @(posedge clock);
      check(out_hiz, 1'b0);
      check(send_diag_msg, 1'b1);
      {lst_req, coil_mon_err, uv_err, ov_err, diag_err} <= 5'h00;
      $display("mute test done");
    end
  endtask

  task t_lock;
    begin
      do_reset;
      axi_wr(`SCFG_ADDR_ENABLE, 32'h7, OK);
      for (i = 0; i < 8; i = i + 1) begin
        if (i != 5) begin
          axi_wr(CF, i, OK);
          axi_wr(NV, 32'ha50 + i, i == 3 ? ER : OK);
          repeat (2) @(posedge clock);
          check(irq, i == 3);
          if (i == 3)
            axi_wr(`SCFG_ADDR_CLEAR, 32'h1, OK);
          else
            check(mem_word, 32'ha50 + i);
        end
      end
      check(wr_cnt, 8'h6);
      axi_wr(`SCFG_ADDR_ENABLE, 32'h2, OK);
      axi_wr(CF, 32'h3, OK);
      axi_wr(NV, 32'h1, ER);
      repeat (2) @(posedge clock);
      check(irq, 1'b0);
      axi_wr(CF, 32'h5, OK);
      axi_wr(CF, 32'h0, ER);
      axi_wr(NV, 32'h2, ER);
      axi_wr(`SCFG_ADDR_ENABLE, 32'h0, ER);
      axi_rd(CF, 32'h5, OK);
      axi_rd(NV, 32'ha57, OK);
      axi_rd(`SCFG_ADDR_STATUS, 32'h3, OK);
      axi_rd(`SCFG_ADDR_MON, 32'hf, OK);
      check(wr_cnt, 8'h6);
      check(irq, 1'b1);
      axi_rd(8'h7c, 32'h0, ER);
      $display("lock test done");
    end
  endtask

  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {lst_req, coil_test_req, diag_err, coil_mon_err, uv_err, ov_err, out_fmt_pwm} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    n_mismatch = 0;
    cmp_count = 0;
    t_reset;
    t_fields;
    t_coil;
    t_mute;
    t_lock;
    print_verdict;
  end
endmodule

bind scfg_top scfg_props scfg_props_i (.*);
